// file: rpmc_pkg.sv
// Purpose: Constants and carriers for the repeater port management counters
// Assumes: One 125 MHz clock, synchronous active-low reset
// Notes:   Counters are free running and wrap; nothing here is software reset
//
// Contract
// RULE1 - 10 Mb/s: count carrier events longer than the jabber lockup timer.
// RULE2 - 100 Mb/s: count each entry to the receive-jabber state.
// RULE3 - Method A: no collision, activity over minimum time, rate mismatch.
// RULE4 - Method B: no collision, octet total above 63, rate mismatch.
// RULE5 - Count a rate mismatch per frame meeting the one chosen method.
// RULE6 - Other counters may also count on a mismatch frame.
// RULE7 - Count each automatic partition; 100 Mb/s on partition-wait entry.
// RULE8 - Count each false-carrier to link-unstable transition as isolation.
// RULE9 - Isolation leaves the administrative port state unchanged.
// RULE10 - Count valid-length packets with symbol errors; once per event.
// RULE11 - A collision on any repeater port blocks the symbol-error count.
// RULE12 - Hold the source address of the last readable frame.
// RULE13 - Count each change of the stored last source address.
// RULE14 - Port counters are free running and cannot be reset by software.
// RULE15 - Admin action sets state; enabling also begins partitioning.
// RULE16 - Each medium unit has an integer id unique within its container.
// RULE17 - Medium type reads as the clause number of the internal unit.
// RULE18 - With an external unit reached via AUI, medium type reads AUI.
// RULE19 - Writing a supported type forces that mode via force bits. (mode_force is set only while i_mii_present is high.)
// RULE20 - With auto-negotiation, a write narrows ability and renegotiates.
// RULE21 - Any medium type change also shows in the physical-layer type.
// RULE22 - Counters are 32 bits and wrap; no saturation, no clear on read.
package rpmc_pkg;

  // ---------------------------------------------------------------
  // Widths and constants
  // ---------------------------------------------------------------
  localparam int          CNT_W         = 32;
  localparam int          ADDR_W        = 48;
  localparam int          TYPE_W        = 8;
  localparam int          ID_W          = 16;
  localparam logic [15:0] OCTET_MIN_B   = 16'h003f;
  localparam logic [CNT_W-1:0] CNT_RST  = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 48'h0000_0000_0000;

  // Medium types, value equals specifying clause number
  localparam logic [TYPE_W-1:0] MT_UNKNOWN = 8'h00;
  localparam logic [TYPE_W-1:0] MT_AUI     = 8'h07;
  localparam logic [TYPE_W-1:0] MT_B5      = 8'h08;
  localparam logic [TYPE_W-1:0] MT_FOIRL   = 8'h09;
  localparam logic [TYPE_W-1:0] MT_B2      = 8'h0a;
  localparam logic [TYPE_W-1:0] MT_BROAD   = 8'h0b;
  localparam logic [TYPE_W-1:0] MT_T       = 8'h0e;
  localparam logic [TYPE_W-1:0] MT_FP      = 8'h10;
  localparam logic [TYPE_W-1:0] MT_FB      = 8'h11;
  localparam logic [TYPE_W-1:0] MT_FL      = 8'h12;
  localparam logic [TYPE_W-1:0] MT_T4      = 8'h17;
  localparam logic [TYPE_W-1:0] MT_TX      = 8'h19;
  localparam logic [TYPE_W-1:0] MT_FX      = 8'h1a;
  localparam logic [TYPE_W-1:0] MT_RST     = MT_UNKNOWN;

  // Arbitrary default identifier
  localparam logic [ID_W-1:0]   UNIT_ID_DEF = 16'h0001;

  typedef enum logic { RPMC_METHOD_A, RPMC_METHOD_B } rpmc_method_e;
  typedef enum logic { RPMC_ADMIN_DISABLED, RPMC_ADMIN_ENABLED } rpmc_admin_e;

  // End-of-frame report from the port receive logic
  typedef struct packed {
    logic              done;
    logic              collision_seen;
    logic              readable;
    logic              rate_mismatch;
    logic              over_valid_min;
    logic              over_jabber_lockup;
    logic              symbol_error;
    logic              valid_length;
    logic [15:0]       octet_total;
    logic [ADDR_W-1:0] src_addr;
  } rpmc_frame_s;

  // Single-cycle state machine events
  typedef struct packed {
    logic rx_jabber_entry;
    logic partition_entry;
    logic false_to_unstable;
    logic any_port_collision;
  } rpmc_evt_s;

  typedef struct packed {
    logic [CNT_W-1:0] very_long_event_count;
    logic [CNT_W-1:0] rate_mismatch_count;
    logic [CNT_W-1:0] auto_partition_count;
    logic [CNT_W-1:0] isolate_count;
    logic [CNT_W-1:0] packet_symbol_error_count;
    logic [CNT_W-1:0] src_addr_change_count;
  } rpmc_cnt_s;

  // Medium control outputs
  typedef struct packed {
    logic [TYPE_W-1:0] medium_unit_type;
    logic [TYPE_W-1:0] phy_type_object;
    logic [TYPE_W-1:0] adv_type;
    logic              mode_force;
    logic              renegotiate;
  } rpmc_mau_s;

endpackage

// file: rpmc_counters.sv
// Purpose: Port statistics, admin state and medium type control
// Assumes: Inputs come from logic on i_ref_clk; no software register bus
// Notes:   Counter outputs are registered and wrap at 32 bits
module rpmc_counters #(
  parameter rpmc_pkg::rpmc_method_e METHOD = rpmc_pkg::RPMC_METHOD_A,
  parameter logic [15:0]            UNIT_ID = rpmc_pkg::UNIT_ID_DEF
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_speed_100,
  input  wire rpmc_pkg::rpmc_frame_s i_frame,
  input  wire rpmc_pkg::rpmc_evt_s   i_evt,
  input  wire logic                  i_admin_wr,
  input  wire rpmc_pkg::rpmc_admin_e i_admin_val,
  input  wire logic                  i_type_wr,
  input  wire logic [7:0]            i_type_val,
  input  wire logic                  i_aui_external,
  input  wire logic                  i_autoneg_on,
  input  wire logic                  i_mii_present,
  output rpmc_pkg::rpmc_cnt_s        o_cnt,
  output logic [47:0]                o_last_src_addr,
  output rpmc_pkg::rpmc_admin_e      o_port_admin_state,
  output logic                       o_partition_begin,
  output logic [15:0]                o_medium_unit_id,
  output rpmc_pkg::rpmc_mau_s        o_mau,
  output logic                       o_type_reject
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rpmc_pkg::rpmc_cnt_s   cnt;
    logic [47:0]           last_src_addr;
    logic                  addr_valid;
    rpmc_pkg::rpmc_admin_e admin;
    logic                  part_begin;
    rpmc_pkg::rpmc_mau_s   mau;
    logic                  type_reject;
  } rpmc_state_s;

  rpmc_state_s state_reg;
  rpmc_state_s state_next;

  logic mismatch_a;
  logic mismatch_b;
  logic mismatch_hit;
  logic long_hit;
  logic symerr_hit;
  logic addr_changed;
  logic type_ok;

  function automatic logic rpmc_type_supported(input logic [7:0] t);
    case (t)
      rpmc_pkg::MT_AUI, rpmc_pkg::MT_B5, rpmc_pkg::MT_FOIRL,
      rpmc_pkg::MT_B2, rpmc_pkg::MT_BROAD, rpmc_pkg::MT_T,
      rpmc_pkg::MT_FP, rpmc_pkg::MT_FB, rpmc_pkg::MT_FL,
      rpmc_pkg::MT_T4, rpmc_pkg::MT_TX, rpmc_pkg::MT_FX:
        rpmc_type_supported = 1'b1;
      default:
        rpmc_type_supported = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  always_comb begin
    mismatch_a = i_frame.done && !i_frame.collision_seen &&
                 i_frame.over_valid_min && i_frame.rate_mismatch; // [RULE3]
    mismatch_b = i_frame.done && !i_frame.collision_seen &&
                 (i_frame.octet_total > rpmc_pkg::OCTET_MIN_B) &&
                 i_frame.rate_mismatch; // [RULE4]
    // Only the configured method counts [RULE5]
    // Other counters count independently [RULE6]
    mismatch_hit = (METHOD == rpmc_pkg::RPMC_METHOD_A) ? mismatch_a
                                                        : mismatch_b;
    long_hit = i_speed_100 ? i_evt.rx_jabber_entry // [RULE2]
                           : (i_frame.done &&
                              i_frame.over_jabber_lockup); // [RULE1]
    // Done fires once per carrier event, bounding one count
    symerr_hit = i_frame.done && i_frame.valid_length && // [RULE10]
                 i_frame.symbol_error &&
                 !i_evt.any_port_collision; // [RULE11]
    addr_changed = i_frame.done && i_frame.readable &&
                   state_reg.addr_valid &&
                   (i_frame.src_addr != state_reg.last_src_addr); // [RULE13]
    type_ok = rpmc_type_supported(i_type_val);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.part_begin = 1'b0;
    state_next.mau.renegotiate = 1'b0;
    state_next.type_reject = 1'b0;

    // Free running wrap, no software clear path [RULE14] [RULE22]
    if (long_hit) begin
      state_next.cnt.very_long_event_count =
        state_reg.cnt.very_long_event_count + 32'h0000_0001;
    end
    if (mismatch_hit) begin
      state_next.cnt.rate_mismatch_count =
        state_reg.cnt.rate_mismatch_count + 32'h0000_0001; // [RULE5]
    end
    if (i_evt.partition_entry) begin
      state_next.cnt.auto_partition_count =
        state_reg.cnt.auto_partition_count + 32'h0000_0001; // [RULE7]
    end
    if (i_evt.false_to_unstable) begin
      // Admin state deliberately untouched here [RULE9]
      state_next.cnt.isolate_count =
        state_reg.cnt.isolate_count + 32'h0000_0001; // [RULE8]
    end
    if (symerr_hit) begin
      state_next.cnt.packet_symbol_error_count =
        state_reg.cnt.packet_symbol_error_count + 32'h0000_0001; // [RULE10]
    end
    if (addr_changed) begin
      state_next.cnt.src_addr_change_count =
        state_reg.cnt.src_addr_change_count + 32'h0000_0001; // [RULE13]
    end

    if (i_frame.done && i_frame.readable) begin
      state_next.last_src_addr = i_frame.src_addr; // [RULE12]
      state_next.addr_valid = 1'b1;
    end

    if (i_admin_wr) begin
      state_next.admin = i_admin_val; // [RULE15]
      state_next.part_begin =
        (i_admin_val == rpmc_pkg::RPMC_ADMIN_ENABLED); // [RULE15]
    end

    if (i_type_wr) begin
      if (type_ok) begin
        state_next.mau.medium_unit_type = i_type_val; // [RULE19]
        state_next.mau.phy_type_object = i_type_val; // [RULE21]
        state_next.mau.mode_force = i_mii_present; // [RULE19]
        if (i_autoneg_on) begin
          state_next.mau.adv_type = i_type_val; // [RULE20]
          state_next.mau.renegotiate = 1'b1; // [RULE20]
        end
      end else begin
        state_next.type_reject = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_reg.cnt.very_long_event_count <= rpmc_pkg::CNT_RST;
      state_reg.cnt.rate_mismatch_count <= rpmc_pkg::CNT_RST;
      state_reg.cnt.auto_partition_count <= rpmc_pkg::CNT_RST;
      state_reg.cnt.isolate_count <= rpmc_pkg::CNT_RST;
      state_reg.cnt.packet_symbol_error_count <= rpmc_pkg::CNT_RST;
      state_reg.cnt.src_addr_change_count <= rpmc_pkg::CNT_RST;
      state_reg.last_src_addr <= rpmc_pkg::ADDR_RST;
      state_reg.addr_valid <= 1'b0;
      state_reg.admin <= rpmc_pkg::RPMC_ADMIN_ENABLED;
      state_reg.part_begin <= 1'b0;
      state_reg.mau.medium_unit_type <= rpmc_pkg::MT_RST;
      state_reg.mau.phy_type_object <= rpmc_pkg::MT_RST;
      state_reg.mau.adv_type <= rpmc_pkg::MT_RST;
      state_reg.mau.mode_force <= 1'b0;
      state_reg.mau.renegotiate <= 1'b0;
      state_reg.type_reject <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    o_cnt = state_reg.cnt;
    o_last_src_addr = state_reg.last_src_addr;
    o_port_admin_state = state_reg.admin;
    o_partition_begin = state_reg.part_begin;
    o_medium_unit_id = UNIT_ID; // [RULE16]
    o_mau = state_reg.mau;
    // External unit through AUI always reads as AUI [RULE18]
    // Internal unit reads its clause number [RULE17]
    o_mau.medium_unit_type = i_aui_external ? rpmc_pkg::MT_AUI
                                            : state_reg.mau.medium_unit_type;
    o_type_reject = state_reg.type_reject;
  end

endmodule

// file: rpmc_checker.sv
// Purpose: Port-level checks for rpmc_counters
// Assumes: Method taken from the bound instance
// Notes:   Bound to every rpmc_counters instance
module rpmc_checker #(
  parameter rpmc_pkg::rpmc_method_e METHOD = rpmc_pkg::RPMC_METHOD_A
) (
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_speed_100,
  input wire rpmc_pkg::rpmc_frame_s i_frame,
  input wire rpmc_pkg::rpmc_evt_s   i_evt,
  input wire logic                  i_admin_wr,
  input wire rpmc_pkg::rpmc_admin_e i_admin_val,
  input wire logic                  i_type_wr,
  input wire logic [7:0]            i_type_val,
  input wire logic                  i_aui_external,
  input wire logic                  i_autoneg_on,
  input wire rpmc_pkg::rpmc_cnt_s   o_cnt,
  input wire logic [47:0]           o_last_src_addr,
  input wire rpmc_pkg::rpmc_admin_e o_port_admin_state,
  input wire logic                  o_partition_begin,
  input wire rpmc_pkg::rpmc_mau_s   o_mau
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  chk_long_ten: assert property (
    i_frame.done && i_frame.over_jabber_lockup && !i_speed_100 |=>
    o_cnt.very_long_event_count == $past(o_cnt.very_long_event_count) + 1)
    else $error("very long count missed at 10");
  chk_long_jab: assert property (
    i_speed_100 && i_evt.rx_jabber_entry |=>
    o_cnt.very_long_event_count == $past(o_cnt.very_long_event_count) + 1)
    else $error("very long count missed at 100");
  chk_rate_cnt: assert property (
    i_frame.done && !i_frame.collision_seen && i_frame.rate_mismatch &&
    ((METHOD == rpmc_pkg::RPMC_METHOD_A) ? i_frame.over_valid_min
      : (i_frame.octet_total > rpmc_pkg::OCTET_MIN_B)) |=>
    o_cnt.rate_mismatch_count == $past(o_cnt.rate_mismatch_count) + 1)
    else $error("rate mismatch count missed");
  chk_iso_cnt: assert property (
    i_evt.false_to_unstable |=>
    o_cnt.isolate_count == $past(o_cnt.isolate_count) + 1)
    else $error("isolation count missed");
  chk_iso_admin: assert property (
    i_evt.false_to_unstable && !i_admin_wr |=> $stable(o_port_admin_state))
    else $error("isolation changed admin state");
  chk_sym_coll: assert property (
    i_frame.done && i_evt.any_port_collision |=>
    $stable(o_cnt.packet_symbol_error_count))
    else $error("symbol count moved under collision");
  chk_addr_keep: assert property (
    i_frame.done && i_frame.readable |=>
    o_last_src_addr == $past(i_frame.src_addr))
    else $error("last source address not stored");
  chk_admin_begin: assert property (
    i_admin_wr && i_admin_val == rpmc_pkg::RPMC_ADMIN_ENABLED |=>
    o_partition_begin && o_port_admin_state == rpmc_pkg::RPMC_ADMIN_ENABLED)
    else $error("enable action gave no begin");
  chk_type_neg: assert property (
    i_type_wr && i_type_val == rpmc_pkg::MT_TX && i_autoneg_on |=>
    o_mau.renegotiate && o_mau.adv_type == rpmc_pkg::MT_TX)
    else $error("type write did not renegotiate");
  chk_aui_type: assert property (
    i_aui_external |-> o_mau.medium_unit_type == rpmc_pkg::MT_AUI)
    else $error("external unit type not AUI");
  cover property (o_partition_begin);
  cover property (o_mau.renegotiate);
  cover property (i_frame.done && i_frame.readable);
endmodule
bind rpmc_counters rpmc_checker #(.METHOD(METHOD)) u_rpmc_checker (
  .i_ref_clk, .i_rst_n,
  .i_speed_100, .i_frame, .i_evt, .i_admin_wr, .i_admin_val, .i_type_wr,
  .i_type_val, .i_aui_external, .i_autoneg_on, .o_cnt, .o_last_src_addr,
  .o_port_admin_state, .o_partition_begin, .o_mau);

// file: rpmc_counters_tb.sv
// Purpose: Self-checking bench for rpmc_counters
// Assumes: Method A on the main instance, method B on the second
// Notes:   Scenarios run in a fixed order; expected counts are absolute
module rpmc_counters_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Stimulus and checks
  // ---------------------------------------------------------------
  logic                  i_ref_clk = 0, i_rst_n = 0, i_speed_100 = 0;
  logic                  i_admin_wr = 0, i_type_wr = 0, i_aui_external = 0;
  logic                  i_autoneg_on = 0, i_mii_present = 0;
  logic [7:0]            i_type_val = 8'h00;
  rpmc_pkg::rpmc_frame_s i_frame = '0;
  rpmc_pkg::rpmc_evt_s   i_evt = '0;
  rpmc_pkg::rpmc_admin_e i_admin_val = rpmc_pkg::RPMC_ADMIN_ENABLED;
  rpmc_pkg::rpmc_cnt_s   o_cnt;
  rpmc_pkg::rpmc_cnt_s   o_cnt_b;
  rpmc_pkg::rpmc_admin_e o_port_admin_state;
  rpmc_pkg::rpmc_mau_s   o_mau;
  logic [47:0]           o_last_src_addr;
  logic [15:0]           o_medium_unit_id;
  logic                  o_partition_begin, o_type_reject;
  int                    errors = 0, n_checks = 0, cyc = 0;
  logic [7:0]            codes [12] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
    8'h0e, 8'h10, 8'h11, 8'h12, 8'h17, 8'h1a, 8'h19};

  rpmc_counters u_rpmc_counters (.i_ref_clk, .i_rst_n, .i_speed_100,
    .i_frame, .i_evt, .i_admin_wr, .i_admin_val, .i_type_wr, .i_type_val,
    .i_aui_external, .i_autoneg_on, .i_mii_present, .o_cnt, .o_last_src_addr,
    .o_port_admin_state, .o_partition_begin, .o_medium_unit_id, .o_mau,
    .o_type_reject);

  // Second instance exercises the octet-count mismatch method
  rpmc_counters #(.METHOD(rpmc_pkg::RPMC_METHOD_B)) u_rpmc_counters_b (
    .i_ref_clk, .i_rst_n, .i_speed_100, .i_frame, .i_evt, .i_admin_wr,
    .i_admin_val, .i_type_wr, .i_type_val, .i_aui_external, .i_autoneg_on,
    .i_mii_present, .o_cnt(o_cnt_b), .o_last_src_addr(),
    .o_port_admin_state(), .o_partition_begin(), .o_medium_unit_id(),
    .o_mau(), .o_type_reject());

  initial forever #4 i_ref_clk = ~i_ref_clk;

  task automatic check(string name, logic [47:0] exp, logic [47:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic hit(rpmc_pkg::rpmc_frame_s f, rpmc_pkg::rpmc_evt_s e);
    @(posedge i_ref_clk);
    i_frame <= f;
    i_evt <= e;
    @(posedge i_ref_clk);
    i_frame <= '0;
    i_evt <= '0;
    #1;
  endtask

  task automatic admin(rpmc_pkg::rpmc_admin_e v);
    @(posedge i_ref_clk);
    i_admin_wr <= 1'b1;
    i_admin_val <= v;
    @(posedge i_ref_clk);
    i_admin_wr <= 1'b0;
    #1;
  endtask

  task automatic tw(logic [7:0] v);
    @(posedge i_ref_clk);
    i_type_wr <= 1'b1;
    i_type_val <= v;
    @(posedge i_ref_clk);
    i_type_wr <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    for (int k = 0; k < 4; k++) begin
      check("cnt", '0, o_cnt[k*48 +: 48]);
    end
    check("cnt_b", '0, o_cnt_b.rate_mismatch_count);
    check("addr", '0, o_last_src_addr);
    check("admin", 1, o_port_admin_state);
    check("id", rpmc_pkg::UNIT_ID_DEF, o_medium_unit_id);
  endtask

  task automatic t_long();
    hit('{done:1'b1, over_jabber_lockup:1'b1, default:'0}, '0);
    check("long", 1, o_cnt.very_long_event_count);
    @(posedge i_ref_clk);
    i_speed_100 <= 1'b1;
    hit('{done:1'b1, over_jabber_lockup:1'b1, default:'0}, '0);
    check("long", 1, o_cnt.very_long_event_count);
    hit('0, '{rx_jabber_entry:1'b1, default:'0});
    check("long", 2, o_cnt.very_long_event_count);
  endtask

  task automatic t_rate();
    hit('{done:1'b1, rate_mismatch:1'b1, over_valid_min:1'b1, default:'0}, '0);
    check("rate", 1, o_cnt.rate_mismatch_count);
    check("rate_b", 0, o_cnt_b.rate_mismatch_count);
    hit('{done:1'b1, rate_mismatch:1'b1, over_valid_min:1'b1,
      octet_total:16'h0040, collision_seen:1'b1, default:'0}, '0);
    check("rate", 1, o_cnt.rate_mismatch_count);
    check("rate_b", 0, o_cnt_b.rate_mismatch_count);
    hit('{done:1'b1, rate_mismatch:1'b1, octet_total:16'h0040,
      default:'0}, '0);
    check("rate", 1, o_cnt.rate_mismatch_count);
    check("rate_b", 1, o_cnt_b.rate_mismatch_count);
    hit('{done:1'b1, rate_mismatch:1'b1, octet_total:16'h003f,
      default:'0}, '0);
    check("rate_b", 1, o_cnt_b.rate_mismatch_count);
  endtask

  task automatic t_sym();
    hit('{done:1'b1, valid_length:1'b1, symbol_error:1'b1, default:'0}, '0);
    check("sym", 1, o_cnt.packet_symbol_error_count);
    hit('{done:1'b1, valid_length:1'b1, symbol_error:1'b1, default:'0},
      '{any_port_collision:1'b1, default:'0});
    check("sym", 1, o_cnt.packet_symbol_error_count);
    hit('{done:1'b1, symbol_error:1'b1, default:'0}, '0);
    check("sym", 1, o_cnt.packet_symbol_error_count);
  endtask

  task automatic t_addr();
    hit('{done:1'b1, readable:1'b1, src_addr:48'h1234, default:'0}, '0);
    check("addr", 48'h1234, o_last_src_addr);
    check("chg", 0, o_cnt.src_addr_change_count);
    hit('{done:1'b1, src_addr:48'h5678, default:'0}, '0);
    check("addr", 48'h1234, o_last_src_addr);
    hit('{done:1'b1, readable:1'b1, src_addr:48'h5678, default:'0}, '0);
    check("chg", 1, o_cnt.src_addr_change_count);
  endtask

  task automatic t_admin_iso();
    admin(rpmc_pkg::RPMC_ADMIN_DISABLED);
    check("admin", 0, o_port_admin_state);
    check("begin", 0, o_partition_begin);
    hit('0, '{partition_entry:1'b1, false_to_unstable:1'b1, default:'0});
    check("part", 1, o_cnt.auto_partition_count);
    check("iso", 1, o_cnt.isolate_count);
    check("admin", 0, o_port_admin_state);
    admin(rpmc_pkg::RPMC_ADMIN_ENABLED);
    check("begin", 1, o_partition_begin);
    @(posedge i_ref_clk);
    #1;
    check("begin", 0, o_partition_begin);
  endtask

  task automatic t_type();
    tw(8'h0e);
    check("type", 8'h0e, o_mau.medium_unit_type);
    check("reneg", 0, o_mau.renegotiate);
    check("adv", 8'h00, o_mau.adv_type);
    check("force", 0, o_mau.mode_force);
    @(posedge i_ref_clk);
    i_autoneg_on <= 1'b1;
    i_mii_present <= 1'b1;
    foreach (codes[k]) begin
      tw(codes[k]);
      check("type", codes[k], o_mau.medium_unit_type);
      check("phy", codes[k], o_mau.phy_type_object);
    end
    check("adv", 8'h19, o_mau.adv_type);
    check("reneg", 1, o_mau.renegotiate);
    check("force", 1, o_mau.mode_force);
    tw(8'h01);
    check("reject", 1, o_type_reject);
    check("type", 8'h19, o_mau.medium_unit_type);
    @(posedge i_ref_clk);
    i_aui_external <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    check("type", 8'h07, o_mau.medium_unit_type);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    t_reset();
    t_long();
    t_rate();
    t_sym();
    t_addr();
    t_admin_iso();
    t_type();
    finish_test();
  end
endmodule
